// ### hdl/hoc_pkg.sv
// Purpose: shared constants and types for the holdover controller
// Assumes: 20 MHz system clock, 24-bit serial frames
// Notes:   register offsets are 13-bit frame addresses
package hoc_pkg;
  localparam int          FRAME_BITS   = 24;
  localparam int          ADDR_BITS    = 13;
  localparam int          DATA_BITS    = 8;
  localparam int          HDR_BITS     = 16;
  localparam logic [12:0] A_SOFT_RESET = 13'h0000;
  localparam logic [12:0] A_OPT_TUNE_A = 13'h0171;
  localparam logic [12:0] A_OPT_TUNE_B = 13'h0172;
  localparam logic [12:0] A_VCO_OPT_1  = 13'h017c;
  localparam logic [12:0] A_VCO_OPT_2  = 13'h017d;
  localparam logic [12:0] A_LOCK_0     = 13'h1ffd;
  localparam logic [12:0] A_LOCK_1     = 13'h1ffe;
  localparam logic [12:0] A_LOCK_2     = 13'h1fff;
  // registers for loose control bits, plus read-only dac read-back and status
  localparam logic [12:0] A_HO_CTRL    = 13'h0150;
  localparam logic [12:0] A_FIX_DAC    = 13'h0151;
  localparam logic [12:0] A_DAC_MULT   = 13'h0152;
  localparam logic [12:0] A_DAC_CNTR   = 13'h0153;
  localparam logic [12:0] A_WND_SIZE   = 13'h0154;
  localparam logic [12:0] A_HOLD_CNT   = 13'h0155;
  localparam logic [12:0] A_STAT_SEL   = 13'h0156;
  localparam logic [12:0] A_DAC_RB     = 13'h0157;
  localparam logic [12:0] A_STATUS     = 13'h0158;
  // control and soft reset register bit positions
  localparam int          B_HO_EN      = 0;
  localparam int          B_FIX_SEL    = 1;
  localparam int          B_TRACK_EN   = 2;
  localparam int          B_HO_EXIT    = 3;
  localparam int          B_SRESET     = 7;
  // status pin selections
  localparam logic [1:0]  SEL_LOCK1    = 2'h0;
  localparam logic [1:0]  SEL_LOCK2    = 2'h1;
  localparam logic [1:0]  SEL_DACACQ   = 2'h2;
  localparam logic [1:0]  SEL_HOLD     = 2'h3;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [7:0]  RST_MULT     = 8'h01;
  localparam logic [7:0]  RST_CNTR     = 8'h01;
  localparam logic [7:0]  RST_WND      = 8'h04;
  localparam logic [7:0]  RST_HOLD     = 8'h08;
  localparam logic [7:0]  RST_DAC      = 8'h80;
  // frame header fields
  typedef struct packed {
    logic                 rd;
    logic [1:0]           mb;
    logic [ADDR_BITS-1:0] addr;
  } hoc_hdr_t;
  // phase comparison report from the loop
  typedef struct packed {
    logic       valid;
    logic       in_window;
    logic [7:0] err;
  } hoc_cmp_t;
endpackage

// ### hdl/hoc_holdover.sv
// Purpose: holdover controller with serial configuration port
// Assumes: serial pins asynchronous, sampled by clk_i (link period 400 ns)
// Notes:   analog loop parts live outside; this block steers them
`timescale 1ns/1ps
`default_nettype none
module hoc_holdover #(
  parameter int DAC_BITS  = 10,
  parameter int MULT_BITS = 8
) (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                cs_n_i,
  input  wire logic                sck_i,
  input  wire logic                sdi_i,
  output logic                     sdo_o,
  output logic                     sdo_oe_o,
  input  wire logic                ref_valid_i,
  input  wire logic                pd_tick_i,
  input  wire hoc_pkg::hoc_cmp_t   cmp_i,
  input  wire logic                loop2_lock_i,
  input  wire logic [DAC_BITS-1:0] tune_sense_i,
  output logic [DAC_BITS-1:0]      tune_dac_o,
  output logic                     tune_dac_drive_o,
  output logic                     pump_enable_o,
  output logic                     holdover_o,
  output logic                     status_pin_a_o,
  output logic                     status_pin_b_o
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before any use
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // idle levels: chip select high, serial clock low, so no false edge
      pin_s1_q <= 3'h4;
      pin_s2_q <= 3'h4;
      pin_s3_q <= 3'h4;
    end else begin
      pin_s1_q <= {cs_n_i, sck_i, sdi_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  wire cs_n_w   = pin_s2_q[2];
  wire sck_rise = pin_s2_q[1] & ~pin_s3_q[1];
  wire sck_fall = ~pin_s2_q[1] & pin_s3_q[1];
  wire cs_rise  = pin_s2_q[2] & ~pin_s3_q[2];
  wire sdi_w    = pin_s2_q[0];

  ////////////////////////////////////////////////////////////////////////
  // serial shifter
  logic [hoc_pkg::FRAME_BITS-1:0] shift_q;
  logic [4:0]                     bitcnt_q;
  logic [7:0]                     rdata_q;
  logic                           sdo_q;
  logic [7:0]                     rd_mux_w;
  wire hoc_pkg::hoc_hdr_t hdr_w = shift_q[hoc_pkg::HDR_BITS-1:0];
  wire [7:0] wdata_w  = shift_q[hoc_pkg::DATA_BITS-1:0];
  wire       full_w   = (bitcnt_q == 5'(hoc_pkg::FRAME_BITS));
  wire       in_data  = (bitcnt_q >= 5'(hoc_pkg::HDR_BITS));
  // hdr_w is only stable while the header is the low 16 bits of the shifter
  wire       hdr_done = (bitcnt_q == 5'(hoc_pkg::HDR_BITS));
  logic      rd_frame_q;
  // frame committed on chip select rise, only if at least 24 bits came in; bits past the 24th are ignored
  wire       commit_w = cs_rise & full_w;
  wire       wr_en_w  = commit_w & ~shift_q[hoc_pkg::FRAME_BITS-1];
  wire [12:0] waddr_w = shift_q[hoc_pkg::FRAME_BITS-4 -: hoc_pkg::ADDR_BITS];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_q  <= '0;
      bitcnt_q <= '0;
    end else if (cs_n_w) begin
      bitcnt_q <= '0;
    end else if (sck_rise && !full_w) begin
      shift_q  <= {shift_q[hoc_pkg::FRAME_BITS-2:0], sdi_w};
      bitcnt_q <= bitcnt_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read-back shifter: loads at header end, shifts on falling sck
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q    <= '0;
      rd_frame_q <= 1'b0;
      sdo_q      <= 1'b0;
    end else if (cs_n_w) begin
      rd_frame_q <= 1'b0;
      sdo_q      <= 1'b0;
    end else if (hdr_done && !rd_frame_q && sck_fall) begin
      rd_frame_q <= hdr_w.rd;
      rdata_q    <= {rd_mux_w[6:0], 1'b0};
      sdo_q      <= rd_mux_w[7];
    end else if (rd_frame_q && in_data && sck_fall) begin
      sdo_q   <= rdata_q[7];
      rdata_q <= {rdata_q[6:0], 1'b0};
    end
  end
  assign sdo_o    = sdo_q;
  assign sdo_oe_o = rd_frame_q & ~cs_n_w;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0] soft_reset_q, opt_tuning_a_q, opt_tuning_b_q;
  logic [7:0] vco_opt_first_q, vco_opt_second_q;
  logic [7:0] config_lock_0_q, config_lock_1_q, config_lock_2_q;
  logic [7:0] ho_ctrl_q, fix_dac_q, dac_mult_q, dac_cntr_q;
  logic [7:0] wnd_q, hold_cnt_q, stat_sel_q;
  wire        soft_rst = soft_reset_q[hoc_pkg::B_SRESET];

  // write decode; skipped registers simply keep their defaults
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      soft_reset_q     <= hoc_pkg::RST_BYTE;
      opt_tuning_a_q   <= hoc_pkg::RST_BYTE;
      opt_tuning_b_q   <= hoc_pkg::RST_BYTE;
      vco_opt_first_q  <= hoc_pkg::RST_BYTE;
      vco_opt_second_q <= hoc_pkg::RST_BYTE;
      config_lock_0_q  <= hoc_pkg::RST_BYTE;
      config_lock_1_q  <= hoc_pkg::RST_BYTE;
      config_lock_2_q  <= hoc_pkg::RST_BYTE;
      ho_ctrl_q        <= hoc_pkg::RST_BYTE;
      fix_dac_q        <= hoc_pkg::RST_DAC;
      dac_mult_q       <= hoc_pkg::RST_MULT;
      dac_cntr_q       <= hoc_pkg::RST_CNTR;
      wnd_q            <= hoc_pkg::RST_WND;
      hold_cnt_q       <= hoc_pkg::RST_HOLD;
      stat_sel_q       <= hoc_pkg::RST_BYTE;
    end else begin
      // manual exit bit is a one-shot; soft reset self-clears too
      ho_ctrl_q[hoc_pkg::B_HO_EXIT] <= 1'b0;
      soft_reset_q[hoc_pkg::B_SRESET] <= 1'b0;
      if (wr_en_w) begin
        unique case (waddr_w)
          hoc_pkg::A_SOFT_RESET: soft_reset_q     <= wdata_w;
          hoc_pkg::A_OPT_TUNE_A: opt_tuning_a_q   <= wdata_w;
          hoc_pkg::A_OPT_TUNE_B: opt_tuning_b_q   <= wdata_w;
          hoc_pkg::A_VCO_OPT_1:  vco_opt_first_q  <= wdata_w;
          hoc_pkg::A_VCO_OPT_2:  vco_opt_second_q <= wdata_w;
          hoc_pkg::A_LOCK_0:     config_lock_0_q  <= wdata_w;
          hoc_pkg::A_LOCK_1:     config_lock_1_q  <= wdata_w;
          hoc_pkg::A_LOCK_2:     config_lock_2_q  <= wdata_w;
          hoc_pkg::A_HO_CTRL:    ho_ctrl_q        <= wdata_w;
          hoc_pkg::A_FIX_DAC:    fix_dac_q        <= wdata_w;
          hoc_pkg::A_DAC_MULT:   dac_mult_q       <= wdata_w;
          hoc_pkg::A_DAC_CNTR:   dac_cntr_q       <= wdata_w;
          hoc_pkg::A_WND_SIZE:   wnd_q            <= wdata_w;
          hoc_pkg::A_HOLD_CNT:   hold_cnt_q       <= wdata_w;
          hoc_pkg::A_STAT_SEL:   stat_sel_q       <= wdata_w;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux: same address as the write
  logic [DAC_BITS-1:0] dac_q;
  logic                hold_q, dac_acq_q, lock1_q, lock2_hold_q;
  wire                 lock2_w;
  wire  [7:0] status_w = {4'h0, lock2_w, dac_acq_q, lock1_q, hold_q};
  always_comb begin
    unique case (hdr_w.addr)
      hoc_pkg::A_SOFT_RESET: rd_mux_w = soft_reset_q;
      hoc_pkg::A_OPT_TUNE_A: rd_mux_w = opt_tuning_a_q;
      hoc_pkg::A_OPT_TUNE_B: rd_mux_w = opt_tuning_b_q;
      hoc_pkg::A_VCO_OPT_1:  rd_mux_w = vco_opt_first_q;
      hoc_pkg::A_VCO_OPT_2:  rd_mux_w = vco_opt_second_q;
      hoc_pkg::A_LOCK_0:     rd_mux_w = config_lock_0_q;
      hoc_pkg::A_LOCK_1:     rd_mux_w = config_lock_1_q;
      hoc_pkg::A_LOCK_2:     rd_mux_w = config_lock_2_q;
      hoc_pkg::A_HO_CTRL:    rd_mux_w = ho_ctrl_q;
      hoc_pkg::A_FIX_DAC:    rd_mux_w = fix_dac_q;
      hoc_pkg::A_DAC_MULT:   rd_mux_w = dac_mult_q;
      hoc_pkg::A_DAC_CNTR:   rd_mux_w = dac_cntr_q;
      hoc_pkg::A_WND_SIZE:   rd_mux_w = wnd_q;
      hoc_pkg::A_HOLD_CNT:   rd_mux_w = hold_cnt_q;
      hoc_pkg::A_STAT_SEL:   rd_mux_w = stat_sel_q;
      hoc_pkg::A_DAC_RB:     rd_mux_w = dac_q[DAC_BITS-1 -: 8];
      hoc_pkg::A_STATUS:     rd_mux_w = status_w;
      default:               rd_mux_w = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // control fields
  wire ho_en    = ho_ctrl_q[hoc_pkg::B_HO_EN];
  wire fix_sel  = ho_ctrl_q[hoc_pkg::B_FIX_SEL];
  wire track_en = ho_ctrl_q[hoc_pkg::B_TRACK_EN];
  wire man_exit = ho_ctrl_q[hoc_pkg::B_HO_EXIT];
  wire [DAC_BITS-1:0] fix_val_w = {fix_dac_q, {(DAC_BITS-8){1'b0}}};

  ////////////////////////////////////////////////////////////////////////
  // lock detector: consecutive in-window comparisons
  logic [7:0] lock_cnt_q;
  wire in_win_w = cmp_i.valid & cmp_i.in_window & (cmp_i.err <= wnd_q);
  wire lock_hit = in_win_w & (lock_cnt_q + 8'h01 >= hold_cnt_q);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_cnt_q <= '0;
      lock1_q    <= 1'b0;
    end else if (soft_rst) begin
      lock_cnt_q <= '0;
      lock1_q    <= 1'b0;
    end else if (cmp_i.valid) begin
      if (!in_win_w) begin
        lock_cnt_q <= '0;
        lock1_q    <= 1'b0;
      end else if (lock_hit) begin
        lock1_q    <= ~hold_q | man_exit;
      end else begin
        lock_cnt_q <= lock_cnt_q + 8'h01;
      end
    end else if (hold_q) begin
      lock1_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // holdover entry and exit
  wire enter_w = ho_en & ~ref_valid_i & ~hold_q;
  // regained lock or host write ends holdover
  wire exit_w  = hold_q & (man_exit | ~ho_en | (cmp_i.valid & lock_hit));
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_q       <= 1'b0;
      lock2_hold_q <= 1'b0;
    end else if (soft_rst) begin
      hold_q       <= 1'b0;
      lock2_hold_q <= 1'b0;
    end else if (enter_w) begin
      hold_q       <= 1'b1;
      lock2_hold_q <= loop2_lock_i;
    end else if (exit_w) begin
      hold_q       <= 1'b0;
      lock2_hold_q <= 1'b0;
    end
  end
  assign lock2_w = hold_q ? lock2_hold_q : loop2_lock_i;

  ////////////////////////////////////////////////////////////////////////
  // tracking dac: one update per multiplier x counter pd ticks
  logic [15:0] rate_cnt_q;
  wire  [15:0] rate_top = 16'(dac_mult_q * dac_cntr_q);
  wire         upd_w    = pd_tick_i & (rate_cnt_q + 16'h0001 >= rate_top);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rate_cnt_q <= '0;
      dac_q      <= '0;
      dac_acq_q  <= 1'b0;
    end else if (soft_rst || !track_en) begin
      rate_cnt_q <= '0;
      dac_acq_q  <= 1'b0;
    end else if (enter_w && fix_sel) begin
      dac_q <= fix_val_w;
    end else if (!hold_q && pd_tick_i) begin
      rate_cnt_q <= upd_w ? '0 : rate_cnt_q + 16'h0001;
      if (upd_w) begin
        dac_q     <= tune_sense_i;
        dac_acq_q <= (dac_q == tune_sense_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs to the loop and status pins
  assign holdover_o       = hold_q;
  assign pump_enable_o    = ~hold_q;
  assign tune_dac_drive_o = hold_q;
  assign tune_dac_o       = (hold_q & fix_sel) ? fix_val_w : dac_q;
  wire [3:0] stat_vec = {hold_q, dac_acq_q, lock2_w, lock1_q};
  assign status_pin_a_o = stat_vec[stat_sel_q[1:0]];
  assign status_pin_b_o = stat_vec[stat_sel_q[5:4]];
endmodule
`default_nettype wire

// ### verification/hoc_holdover_sva.sv
// Purpose: port-level checks for the holdover controller
// Assumes: one clock domain, async active-high reset
// Notes:   bound into every hoc_holdover instance
`timescale 1ns/1ps
`default_nettype none
module hoc_holdover_sva #(
  parameter int DAC_BITS = 10
) (
  input wire logic                clk_i,
  input wire logic                sys_rst_i,
  input wire logic                cs_n_i,
  input wire logic                sck_i,
  input wire logic                sdo_o,
  input wire logic                sdo_oe_o,
  input wire logic                ref_valid_i,
  input wire hoc_pkg::hoc_cmp_t   cmp_i,
  input wire logic [DAC_BITS-1:0] tune_dac_o,
  input wire logic                tune_dac_drive_o,
  input wire logic                pump_enable_o,
  input wire logic                holdover_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // two held cycles in a row, then the exit step
  sequence s_held;
    holdover_o [*2];
  endsequence
  sequence s_exit;
    $fell(holdover_o);
  endsequence
  property p_pump_off;   holdover_o |-> !pump_enable_o; endproperty
  property p_drive_on;   holdover_o |-> tune_dac_drive_o; endproperty
  property p_entry;      $rose(holdover_o) |-> $past(!ref_valid_i); endproperty
  property p_dac_steady; s_held |-> $stable(tune_dac_o); endproperty
  property p_oe_start;   $rose(sdo_oe_o) |-> !sck_i && !cs_n_i; endproperty
  property p_sdo_edge;   sdo_oe_o && $changed(sdo_o) |-> !sck_i; endproperty
  property p_oe_off;     $rose(cs_n_i) |-> ##[1:3] !sdo_oe_o; endproperty
  // exit only from a comparison or a landed host write
  property p_exit_cause; s_exit |-> $past(cmp_i.valid) || cs_n_i; endproperty
  property p_pump_back;  s_exit |-> pump_enable_o && !tune_dac_drive_o; endproperty
  a_pump_off:   assert property (p_pump_off) else $error("pump on in holdover");
  a_drive_on:   assert property (p_drive_on) else $error("dac not driving");
  a_entry:      assert property (p_entry) else $error("entry with valid ref");
  a_dac_steady: assert property (p_dac_steady) else $error("dac moved");
  a_oe_start:   assert property (p_oe_start) else $error("sdo enable early");
  a_sdo_edge:   assert property (p_sdo_edge) else $error("sdo changed sck high");
  a_oe_off:     assert property (p_oe_off) else $error("sdo kept after frame");
  a_exit_cause: assert property (p_exit_cause) else $error("exit no cause");
  a_pump_back:  assert property (p_pump_back) else $error("pump not back");
endmodule
bind hoc_holdover hoc_holdover_sva #(.DAC_BITS(DAC_BITS)) i_hoc_holdover_sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
  .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ref_valid_i(ref_valid_i), .cmp_i(cmp_i),
  .tune_dac_o(tune_dac_o), .tune_dac_drive_o(tune_dac_drive_o),
  .pump_enable_o(pump_enable_o), .holdover_o(holdover_o)
);
`default_nettype wire

// ### verification/hoc_host.sv
// Purpose: host controller model for the serial configuration port
// Assumes: link clock 400 ns, idle low between frames
// Notes:   frames are sent whole; no short frames
`timescale 1ns/1ps
`default_nettype none
module hoc_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output var  logic cs_n_o,
  output var  logic sck_o,
  output var  logic sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    sdi_o  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // wait n system clocks, then step off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one 24-bit frame; read data caught on each of the last 8 rising link edges
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 2'b00, a, wd};
    q = 8'h00;
    wt(1);
    cs_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_o = f[i];
      wt(4);
      sck_o = 1'b1;
      if (i < 8) q = {q[6:0], sdo_i};
      wt(4);
      sck_o = 1'b0;
    end
    wt(4);
    cs_n_o = 1'b1;
    sdi_o  = ~sdi_o; // released line must not look held
    wt(8);
  endtask
endmodule
`default_nettype wire

// ### verification/tb_hoc_holdover.sv
// Purpose: self-checking bench for the holdover controller
// Assumes: 20 MHz clock, host model speaks the serial frames
// Notes:   second loop lock held high, except for one drop in t_fixed
`timescale 1ns/1ps
`default_nettype none
module tb_hoc_holdover;
  localparam logic [7:0] EN  = 8'h01 << hoc_pkg::B_HO_EN;
  localparam logic [7:0] FIX = 8'h01 << hoc_pkg::B_FIX_SEL;
  localparam logic [7:0] TRK = 8'h01 << hoc_pkg::B_TRACK_EN;
  localparam logic [7:0] EXT = 8'h01 << hoc_pkg::B_HO_EXIT;
  logic clk, sys_rst, cs_n, sck, sdi, sdo, ref_valid, pd_tick, pin_a, pin_b;
  logic hold, pump, drive, lock2, oe;
  logic [9:0] sense, dac;
  hoc_pkg::hoc_cmp_t cmp;
  int err_count, check_count;
  hoc_holdover i_hoc_holdover (
    .clk_i(clk), .sys_rst_i(sys_rst), .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(oe), .ref_valid_i(ref_valid), .pd_tick_i(pd_tick),
    .cmp_i(cmp), .loop2_lock_i(lock2), .tune_sense_i(sense), .tune_dac_o(dac),
    .tune_dac_drive_o(drive), .pump_enable_o(pump), .holdover_o(hold),
    .status_pin_a_o(pin_a), .status_pin_b_o(pin_b));
  hoc_host i_hoc_host (.clk_i(clk), .sdo_i(sdo), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_hoc_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_hoc_host.xfer(1'b1, a, 8'h00, q);
    chk(24'(q), 24'(e));
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      pd_tick = 1'b1;
      i_hoc_host.wt(1);
      pd_tick = 1'b0;
      i_hoc_host.wt(2);
    end
  endtask
  // comparisons at the edge of the lock window
  task automatic cmps(input logic w, input int n);
    repeat (n) begin
      cmp = {1'b1, w, 8'h04};
      i_hoc_host.wt(1);
      cmp.valid = 1'b0;
      i_hoc_host.wt(1);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // defaults, lock registers in order, unmapped place
  task automatic t_regs;
    chk(24'({hold, pump, dac}), 24'({2'b01, 10'h000}));
    rd(hoc_pkg::A_DAC_MULT, hoc_pkg::RST_MULT);
    rd(hoc_pkg::A_DAC_CNTR, hoc_pkg::RST_CNTR);
    rd(hoc_pkg::A_WND_SIZE, hoc_pkg::RST_WND);
    rd(hoc_pkg::A_HOLD_CNT, hoc_pkg::RST_HOLD);
    rd(hoc_pkg::A_FIX_DAC, hoc_pkg::RST_DAC);
    for (int i = 0; i < 3; i++) wr(hoc_pkg::A_LOCK_0 + 13'(i), 8'(8'h11 * (i + 1)));
    wr(hoc_pkg::A_OPT_TUNE_A, 8'haa);
    wr(hoc_pkg::A_OPT_TUNE_B, 8'h02);
    for (int i = 0; i < 3; i++) rd(hoc_pkg::A_LOCK_0 + 13'(i), 8'(8'h11 * (i + 1)));
    rd(hoc_pkg::A_OPT_TUNE_A, 8'haa);
    rd(hoc_pkg::A_OPT_TUNE_B, 8'h02);
    wr(13'h1000, 8'h55);
    rd(13'h1000, 8'h00);
  endtask
  // tracked value, update spacing, acquired flag, tracked holdover
  task automatic t_track;
    sense = 10'h2a5;
    wr(hoc_pkg::A_DAC_MULT, 8'h02);
    wr(hoc_pkg::A_DAC_CNTR, 8'h03);
    wr(hoc_pkg::A_HO_CTRL, TRK);
    ticks(5);
    rd(hoc_pkg::A_DAC_RB, 8'h00);
    ticks(1);
    rd(hoc_pkg::A_DAC_RB, 8'ha9);
    wr(hoc_pkg::A_STAT_SEL, {2'b00, 2'(hoc_pkg::SEL_LOCK2), 2'b00, 2'(hoc_pkg::SEL_DACACQ)});
    ticks(6);
    chk(24'(pin_a), 24'h1);
    wr(hoc_pkg::A_HO_CTRL, TRK | EN);
    ref_valid = 1'b0;
    i_hoc_host.wt(3);
    chk(24'({drive, dac}), 24'({1'b1, 10'h2a5}));
    ref_valid = 1'b1;
    // leave holdover before changing the select, the held value must not jump
    wr(hoc_pkg::A_HO_CTRL, TRK | EN | EXT);
    wr(hoc_pkg::A_HO_CTRL, TRK | FIX | EN);
    ref_valid = 1'b0;
    i_hoc_host.wt(3);
    chk(24'(dac), 24'({hoc_pkg::RST_DAC, 2'b00}));
    ref_valid = 1'b1;
    wr(hoc_pkg::A_HO_CTRL, EXT);
    chk(24'(hold), 24'h0);
  endtask
  // fixed value, status pins, manual exit, disabled holdover
  task automatic t_fixed;
    wr(hoc_pkg::A_FIX_DAC, 8'h5a);
    wr(hoc_pkg::A_STAT_SEL, {2'b00, 2'(hoc_pkg::SEL_LOCK2), 2'b00, 2'(hoc_pkg::SEL_HOLD)});
    wr(hoc_pkg::A_HO_CTRL, EN | FIX);
    ref_valid = 1'b0;
    i_hoc_host.wt(3);
    chk(24'({hold, pump, drive}), 24'h5);
    chk(24'(dac), 24'({8'h5a, 2'b00}));
    chk(24'({pin_a, pin_b}), 24'h3);
    lock2 = 1'b0;
    i_hoc_host.wt(2);
    chk(24'(pin_b), 24'h1);
    lock2 = 1'b1;
    ref_valid = 1'b1;
    wr(hoc_pkg::A_HO_CTRL, EN | FIX | EXT);
    chk(24'({hold, pump}), 24'h1);
    wr(hoc_pkg::A_HO_CTRL, FIX);
    ref_valid = 1'b0;
    i_hoc_host.wt(3);
    chk(24'(hold), 24'h0);
    ref_valid = 1'b1;
  endtask
  // automatic exit needs an unbroken run of hits
  task automatic t_auto;
    wr(hoc_pkg::A_HO_CTRL, EN | FIX);
    ref_valid = 1'b0;
    i_hoc_host.wt(3);
    ref_valid = 1'b1;
    cmps(1'b1, 7);
    cmps(1'b0, 1);
    cmps(1'b1, 7);
    chk(24'(hold), 24'h1);
    cmps(1'b1, 1);
    i_hoc_host.wt(1);
    chk(24'(hold), 24'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, well past the expected run
  initial begin
    #3ms;
    err_count++;
    end_of_test();
  end
  initial begin
    sys_rst = 1'b1;
    ref_valid = 1'b1;
    lock2 = 1'b1;
    pd_tick = 1'b0;
    sense = 10'h000;
    cmp = '0;
    err_count = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    i_hoc_host.wt(4);
    t_regs();
    t_track();
    t_fixed();
    t_auto();
    end_of_test();
  end
endmodule
`default_nettype wire
